//--- design/srcl_consts.vh
// Constants shared by the serial ROM configuration loader
`ifndef SRCL_CONSTS_VH
`define SRCL_CONSTS_VH
`define SRCL_BITS_PER_BYTE 4'h8
`define SRCL_BIT_CNT_W 3
`define SRCL_BIT_LAST 3'h7
`define SRCL_BIT_ZERO 3'h0
`define SRCL_ADDR_ZERO 16'h0000
`define SRCL_ADDR_ONE 16'h0001
`define SRCL_ST_IDLE 2'h0
`define SRCL_ST_LOAD 2'h1
`define SRCL_ST_DONE 2'h2
`define SRCL_ST_ERROR 2'h3
`endif

//--- design/srcl_buf2.v
// Two-entry valid/ready buffer between the byte packer and the memory writer
`timescale 1ns/100ps
module srcl_buf2 #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0] count;
    wire push;
    wire pop;

    // Full at two entries; a stalled drain holds the filler off
    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = slot0;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Slot 0 is always the head; slot 1 shifts down on a pop
    always @(posedge mclk)
    begin
        if (rst)
        begin
            count <= 2'h0;
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (count == 2'h0)
                        slot0 <= in_data;
                    else
                        slot1 <= in_data;
                    count <= count + 2'h1;
                end
                2'b01:
                begin
                    slot0 <= slot1;
                    count <= count - 2'h1;
                end
                2'b11:
                begin
                    if (count == 2'h1)
                        slot0 <= in_data;
                    else
                    begin
                        slot0 <= slot1;
                        slot1 <= in_data;
                    end
                end
                default:
                begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // srcl_buf2

//--- design/srcl_loader.v
// Serial boot-from-ROM configuration loader: strobe generation, bit packing, memory writes
`timescale 1ns/100ps
`include "srcl_consts.vh"
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Serial bits are packed eight to a byte; each byte is written to config memory.
// - Link uses master clock in, strobe clock out, and one serial data line.
// - Strobe toggles at most once per master clock rise, so at most half its rate.
// - Each strobe rising edge samples one data bit and advances the address counter, except the release on leaving loading.
// - Strobe changes only on a detected master clock rising edge, except that leaving loading releases it at once.
// - Master clock idle phases run sequence steps and capture no data.
// - The data bit is taken at the end of the active master clock phase.
// - Logic is static: any length of master clock low stall is tolerated.
// - Strobe is open drain: driven low only while this device loads.
// - Identity mismatch or checksum error raises error output and stops loading.
module srcl_loader #(
    parameter ADDR_W = 16,
    parameter CONFIG_BYTES = 16'h0400
) (
    // System clock and reset
    input wire mclk,
    input wire rst,
    // Mode and sequence control
    input wire serial_rom_boot_mode,
    input wire start,
    input wire id_mismatch,
    input wire checksum_error,
    // Link pins
    input wire master_cfg_clk,
    input wire serial_config_data,
    input wire data_strobe_clock_in,
    output wire data_strobe_clock_out,
    output wire data_strobe_clock_oe,
    // Configuration memory write port
    output reg cfg_wr_en,
    output reg [ADDR_W-1:0] cfg_wr_addr,
    output reg [7:0] cfg_wr_data,
    input wire cfg_wr_ready,
    // Status
    output reg config_error_out,
    output reg config_done,
    output reg loading
);
    reg [1:0] state;
    reg [1:0] next_state;
    reg mck_s1;
    reg mck_s2;
    reg mck_prev;
    reg dat_s1;
    reg dat_s2;
    reg dsc_s1;
    reg dsc_s2;
    reg strobe_high;
    reg [`SRCL_BIT_CNT_W-1:0] bit_cnt;
    reg [7:0] shift;
    reg byte_valid;
    reg [ADDR_W-1:0] bit_addr;
    reg [ADDR_W-1:0] bytes_written;
    wire mck_rise;
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;
    wire drain;
    wire fault;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers for pins; the first stage feeds nothing else
    always @(posedge mclk)
    begin
        if (rst)
        begin
            mck_s1 <= 1'b0;
            mck_s2 <= 1'b0;
            mck_prev <= 1'b0;
            dat_s1 <= 1'b0;
            dat_s2 <= 1'b0;
            dsc_s1 <= 1'b1;
            dsc_s2 <= 1'b1;
        end
        else
        begin
            mck_s1 <= master_cfg_clk;
            mck_s2 <= mck_s1;
            mck_prev <= mck_s2;
            dat_s1 <= serial_config_data;
            dat_s2 <= dat_s1;
            dsc_s1 <= data_strobe_clock_in;
            dsc_s2 <= dsc_s1;
        end
    end

    // Edge of the master clock; a held-low clock simply yields no edges
    assign mck_rise = mck_s2 && !mck_prev;
    assign fault = id_mismatch || checksum_error;

    ////////////////////////////////////////////////////////////////////////////
    // Sequence state machine
    always @*
    begin
        next_state = state;
        case (state)
            `SRCL_ST_IDLE:
                if (start && serial_rom_boot_mode)
                    next_state = `SRCL_ST_LOAD;
            `SRCL_ST_LOAD:
                if (fault)
                    next_state = `SRCL_ST_ERROR;
                else if (bytes_written == CONFIG_BYTES[ADDR_W-1:0])
                    next_state = `SRCL_ST_DONE;
            `SRCL_ST_DONE:
                if (start)
                    next_state = `SRCL_ST_IDLE;
            default:
                next_state = `SRCL_ST_ERROR; // Stopped until reset
        endcase
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            state <= `SRCL_ST_IDLE;
            config_error_out <= 1'b0;
            config_done <= 1'b0;
            loading <= 1'b0;
        end
        else
        begin
            state <= next_state;
            config_error_out <= (next_state == `SRCL_ST_ERROR);
            config_done <= (next_state == `SRCL_ST_DONE);
            loading <= (next_state == `SRCL_ST_LOAD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe: toggles only on a master clock rise, so at most half its rate.
    // Strobe is held high (bus released) outside loading and while the buffer
    // is full, so a slow memory never loses a byte.
    // A pulled-low strobe goes back up on the next rise together with its sample,
    // or at once on leaving loading; only the pull itself waits for buffer room, so a full buffer
    // can never strand the line low while bits keep arriving.
    always @(posedge mclk)
    begin
        if (rst)
            strobe_high <= 1'b1;
        else if (state != `SRCL_ST_LOAD)
            strobe_high <= 1'b1;
        else if (mck_rise && !strobe_high && dsc_s2 == 1'b0)
            strobe_high <= 1'b1;
        else if (mck_rise && strobe_high && buf_in_ready && !byte_valid)
            strobe_high <= 1'b0;
    end

    // Open drain: only pull low, only while this device loads
    assign data_strobe_clock_out = 1'b0;
    assign data_strobe_clock_oe = !strobe_high && (state == `SRCL_ST_LOAD);

    ////////////////////////////////////////////////////////////////////////////
    // Bit capture on the strobe low-to-high step, which falls at the end of
    // an active master clock phase; the line is read back to honour wired-OR.
    always @(posedge mclk)
    begin
        if (rst)
        begin
            bit_cnt <= `SRCL_BIT_ZERO;
            shift <= 8'h00;
            byte_valid <= 1'b0;
            bit_addr <= `SRCL_ADDR_ZERO;
        end
        else if (state != `SRCL_ST_LOAD)
        begin
            bit_cnt <= `SRCL_BIT_ZERO;
            byte_valid <= 1'b0;
        end
        else
        begin
            if (byte_valid && buf_in_ready)
                byte_valid <= 1'b0;
            if (mck_rise && !strobe_high && dsc_s2 == 1'b0 && !byte_valid)
            begin
                shift <= {shift[6:0], dat_s2};
                bit_addr <= bit_addr + `SRCL_ADDR_ONE;
                if (bit_cnt == `SRCL_BIT_LAST)
                begin
                    bit_cnt <= `SRCL_BIT_ZERO;
                    byte_valid <= 1'b1;
                end
                else
                    bit_cnt <= bit_cnt + 3'h1;
            end
        end
    end

    srcl_buf2 #(
        .WIDTH(8)
    ) u_buf (
        .mclk(mclk),
        .rst(rst),
        .in_valid(byte_valid),
        .in_ready(buf_in_ready),
        .in_data(shift),
        .out_valid(buf_out_valid),
        .out_ready(cfg_wr_ready),
        .out_data(buf_out_data)
    );

    assign drain = buf_out_valid && cfg_wr_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration memory writes, one byte per accepted word
    always @(posedge mclk)
    begin
        if (rst)
        begin
            cfg_wr_en <= 1'b0;
            cfg_wr_addr <= `SRCL_ADDR_ZERO;
            cfg_wr_data <= 8'h00;
            bytes_written <= `SRCL_ADDR_ZERO;
        end
        else
        begin
            cfg_wr_en <= drain;
            if (drain)
            begin
                cfg_wr_addr <= bytes_written;
                cfg_wr_data <= buf_out_data;
                bytes_written <= bytes_written + `SRCL_ADDR_ONE;
            end
            else if (state == `SRCL_ST_IDLE)
                bytes_written <= `SRCL_ADDR_ZERO;
        end
    end
endmodule // srcl_loader

//--- verif/srcl_loader_assertions.sv
// Port checker for the serial ROM configuration loader
`timescale 1ns/100ps
module srcl_loader_chk #(
    parameter ADDR_W = 16,
    parameter CONFIG_BYTES = 16'h0400
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Inputs
    input wire master_cfg_clk,
    input wire id_mismatch,
    input wire checksum_error,
    // Outputs
    input wire data_strobe_clock_oe,
    input wire cfg_wr_en,
    input wire [ADDR_W-1:0] cfg_wr_addr,
    input wire [7:0] cfg_wr_data,
    input wire config_error_out,
    input wire config_done,
    input wire loading
);
default clocking cb @(posedge mclk);
endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
// Pin is synced, so a pull may follow a master rise by a few cycles only
property p_oe_edge;
    $rose(data_strobe_clock_oe) |-> master_cfg_clk && !$past(master_cfg_clk, 6);
endproperty
a_oe_edge: assert property (p_oe_edge) else $error("strobe off rise");
property p_oe_gap;
    $rose(data_strobe_clock_oe) |=> (data_strobe_clock_oe || !loading)[*8];
endproperty
a_oe_gap: assert property (p_oe_gap) else $error("strobe too fast");
property p_oe_load;
    data_strobe_clock_oe |-> loading;
endproperty
a_oe_load: assert property (p_oe_load) else $error("strobe pulled idle");
property p_addr;
    $changed(cfg_wr_addr) |-> cfg_wr_en && cfg_wr_addr == $past(cfg_wr_addr) + 1'h1;
endproperty
a_addr: assert property (p_addr) else $error("bad address step");
property p_data;
    $changed(cfg_wr_data) |-> cfg_wr_en;
endproperty
a_data: assert property (p_data) else $error("data moved");
property p_err_hold;
    config_error_out |=> config_error_out;
endproperty
a_err_hold: assert property (p_err_hold) else $error("error dropped");
property p_err_stop;
    config_error_out |-> !loading && !data_strobe_clock_oe && !config_done;
endproperty
a_err_stop: assert property (p_err_stop) else $error("load not stopped");
property p_err_go;
    (id_mismatch || checksum_error) && loading |-> ##[1:3] config_error_out;
endproperty
a_err_go: assert property (p_err_go) else $error("error missed");
property p_done;
    config_done |-> !loading && !data_strobe_clock_oe;
endproperty
a_done: assert property (p_done) else $error("done while load");
c_wr: cover property (cfg_wr_en);
c_err: cover property ($rose(config_error_out));
c_done: cover property ($rose(config_done));
endmodule // srcl_loader_chk
bind srcl_loader srcl_loader_chk #(.ADDR_W(ADDR_W), .CONFIG_BYTES(CONFIG_BYTES)) i_srcl_loader_chk (
    .mclk, .rst, .master_cfg_clk, .id_mismatch, .checksum_error, .data_strobe_clock_oe,
    .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .config_error_out, .config_done, .loading);

//--- verif/srcl_prom.sv
// Serial PROM model: master clock and serial data
`timescale 1ns/100ps
module srcl_prom (
    // Control
    input wire run,
    input wire slow,
    input wire [31:0] bits,
    // Link
    input wire strobe_pin,
    output reg mcc = 1'h0,
    output reg sdat = 1'h0
);
integer idx = 0;
// A released data line must not show the old bit
always @(negedge run)
begin
    idx = 0;
    sdat = ~sdat;
end
// 64 ns clock in frames, low between them
always
begin
    wait (run);
    #33 mcc = 1'h1;
    #31 mcc = 1'h0;
    // New bit only while strobe is low; stretch only then
    if (run && !strobe_pin && idx < 32)
    begin
        sdat = bits[31-idx];
        idx = idx + 1;
        if (slow)
            #64;
    end
end
endmodule // srcl_prom

//--- verif/srcl_loader_test.sv
// Self-checking bench for the serial ROM configuration loader
`timescale 1ns/100ps
module srcl_loader_test;
reg mclk = 1'h0, rst = 1'h1, mode = 1'h0, start = 1'h0;
reg idm = 1'h0, cke = 1'h0, rdy = 1'h1, run = 1'h0, slow = 1'h0;
reg [31:0] bits = 32'h0;
wire mcc, sdat, oe, dout, wen, err, done, ld;
wire [15:0] wa;
wire [7:0] wd;
integer n_fail = 0, cmp_count = 0, k, j;
reg [15:0] qa[$];
reg [7:0] qd[$];
wire pin = oe ? dout : 1'h1;
always #2 mclk = ~mclk;
srcl_loader #(.CONFIG_BYTES(16'h0004)) i_srcl_loader (.mclk(mclk), .rst(rst),
    .serial_rom_boot_mode(mode), .start(start), .id_mismatch(idm), .checksum_error(cke),
    .master_cfg_clk(mcc), .serial_config_data(sdat), .data_strobe_clock_in(pin),
    .data_strobe_clock_out(dout), .data_strobe_clock_oe(oe), .cfg_wr_en(wen), .cfg_wr_addr(wa),
    .cfg_wr_data(wd), .cfg_wr_ready(rdy), .config_error_out(err), .config_done(done), .loading(ld));
srcl_prom i_srcl_prom (.run(run), .slow(slow), .bits(bits), .strobe_pin(pin), .mcc(mcc), .sdat(sdat));
////////////////////////////////////////////////////////////////////////////////
// Log memory writes
always @(posedge mclk)
begin
    if (wen)
    begin
        qa.push_back(wa);
        qd.push_back(wd);
    end
end
task chk(input [15:0] got, input [15:0] exp);
begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
        n_fail = n_fail + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
end
endtask
task end_sim;
begin
    $display("n_fail=%0d cmp_count=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
end
endtask
// Bounded wait for done (0) or error (1)
task wait_sig(input integer sel, input integer lim);
begin
    k = 0;
    while (((sel == 0) ? done : err) !== 1'h1 && k < lim)
    begin
        @(posedge mclk);
        k = k + 1;
    end
    if (k >= lim)
    begin
        chk(k, 0);
        end_sim;
    end
end
endtask
task do_reset;
begin
    rst <= 1'h1;
    run <= 1'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    qa.delete();
    qd.delete();
    @(posedge mclk);
end
endtask
task go(input [31:0] b, input s, input m);
begin
    bits <= b;
    slow <= s;
    mode <= m;
    start <= 1'h1;
    run <= 1'h1;
    @(posedge mclk);
    start <= 1'h0;
end
endtask
// Full load, memory stalled for hold plus 5 cycles if hold is nonzero, not stalled if hold is 0
task load(input [31:0] b, input s, input integer hold);
begin
    rdy <= (hold == 0);
    go(b, s, 1'h1);
    repeat (hold + 4) @(posedge mclk);
    chk({ld, done, pin}, 3'h5);
    rdy <= 1'h1;
    wait_sig(0, 4000);
    for (j = 0; j < 4; j = j + 1)
    begin
        chk(qa[j], j);
        chk(qd[j], b[31-8*j -: 8]);
    end
    chk(qa.size(), 4);
end
endtask
// A start pulse in the done state returns the loader to idle
task restart;
begin
    start <= 1'h1;
    @(posedge mclk);
    start <= 1'h0;
    repeat (2) @(posedge mclk);
    chk({ld, done, pin}, 3'h1);
end
endtask
// Error in mid-load, id (1) or checksum (0)
task load_err(input c);
begin
    go(32'h5A5A5A5A, 1'h0, 1'h1);
    repeat (400) @(posedge mclk);
    idm <= c;
    cke <= !c;
    wait_sig(1, 20);
    idm <= 1'h0;
    cke <= 1'h0;
    repeat (300) @(posedge mclk);
    chk({err, ld, done, pin, qa.size() == 1}, 5'h13);
end
endtask
task idle_mode;
begin
    go(32'hFFFFFFFF, 1'h0, 1'h0);
    repeat (300) @(posedge mclk);
    chk({ld, pin, qa.size() == 0}, 3'h3);
end
endtask
initial
begin
    do_reset;
    load(32'hA500FF3C, 1'h0, 0);
    restart;
    do_reset;
    load(32'h0F817EC3, 1'h1, 2000);
    do_reset;
    load_err(1'h1);
    do_reset;
    load_err(1'h0);
    do_reset;
    idle_mode;
    end_sim;
end
endmodule // srcl_loader_test
